// >>> design/i2cpx_top.sv
`timescale 1ns/100ps
module i2cpx_top
  import i2cpx_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic BUS_CLEAR_N_IN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  input wire logic [1:0] ADDR_SELECT_LOW_IN,
  input wire logic [1:0] ADDR_SELECT_HIGH_IN,
  input wire logic [7:0] PUSH_PULL_DEFAULT_IN,
  input wire logic [7:0] OPEN_DRAIN_DEFAULT_IN,
  output logic [7:0] PUSH_PULL_OUT,
  input wire logic [7:0] OPEN_DRAIN_IO_IN,
  output logic [7:0] OPEN_DRAIN_IO_OUT,
  output logic [7:0] OPEN_DRAIN_IO_OE_OUT,
  output logic CHANGE_ALERT_OUT,
  output logic CHANGE_ALERT_OE_OUT
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  // Pins share one two-stage chain; stage one feeds stage two only
  localparam int unsigned SYNC_W = 31;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic scl_s, sda_s, bus_clr_n_s;
  logic [3:0] addr_low_s;
  logic [7:0] pp_def_s, od_def_s, od_pin_s;
  logic scl_d_reg, sda_d_reg;

  always_ff @(posedge SYS_CLK_IN) begin
    sync1_reg <= {SCL_IN, SDA_IN, BUS_CLEAR_N_IN, ADDR_SELECT_HIGH_IN, ADDR_SELECT_LOW_IN,
                  PUSH_PULL_DEFAULT_IN, OPEN_DRAIN_DEFAULT_IN, OPEN_DRAIN_IO_IN};
    sync2_reg <= sync1_reg;
  end

  assign {scl_s, sda_s, bus_clr_n_s, addr_low_s, pp_def_s, od_def_s, od_pin_s} = sync2_reg;

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // Edges are taken at 25 system clocks per bus bit at the top rate
  logic scl_rise, scl_fall, start_cond, stop_cond;
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign start_cond = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_cond = scl_s && scl_d_reg && !sda_d_reg && sda_s;

  // ****************************************
  // Serial engine
  // ****************************************
  i2cpx_state_e state_reg;
  logic [7:0] shift_reg;
  logic [3:0] cnt_reg;
  logic bank_od_reg;
  logic sda_oe_reg;
  logic addr_hit_pp, addr_hit_od, byte_done;
  logic access_pulse, pp_wr_pulse, od_wr_pulse;
  logic [7:0] read_src;

  assign byte_done = scl_fall && (cnt_reg == BITS_PER_BYTE);
  assign addr_hit_pp = shift_reg[7:1] == {PUSH_PULL_PREFIX, addr_low_s};
  assign addr_hit_od = shift_reg[7:1] == {OPEN_DRAIN_PREFIX, addr_low_s};
  assign access_pulse = (state_reg == ST_ADDR) && byte_done && (addr_hit_pp || addr_hit_od) && bus_clr_n_s;
  assign pp_wr_pulse = (state_reg == ST_WRITE) && byte_done && !bank_od_reg && bus_clr_n_s;
  assign od_wr_pulse = (state_reg == ST_WRITE) && byte_done && bank_od_reg && bus_clr_n_s;

  logic [7:0] pp_reg, od_reg;
  // Open-drain bank reads the pins, so a port held low externally reads low
  assign read_src = bank_od_reg ? od_pin_s : pp_reg;

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN || !bus_clr_n_s) begin
      state_reg <= ST_IDLE;
      shift_reg <= BYTE_ZERO;
      cnt_reg <= CNT_ZERO;
      bank_od_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (stop_cond) begin
      state_reg <= ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (start_cond) begin
      state_reg <= ST_ADDR;
      cnt_reg <= CNT_ZERO;
      sda_oe_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            cnt_reg <= cnt_reg + 4'h1;
          end else if (byte_done) begin
            if (addr_hit_pp || addr_hit_od) begin
              state_reg <= ST_ADDR_ACK;
              bank_od_reg <= addr_hit_od;
              sda_oe_reg <= 1'b1;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            cnt_reg <= CNT_ZERO;
            if (shift_reg[0]) begin
              state_reg <= ST_READ;
              shift_reg <= read_src;
              sda_oe_reg <= !read_src[7];
            end else begin
              state_reg <= ST_WRITE;
              sda_oe_reg <= 1'b0;
            end
          end
        end
        ST_WRITE: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            cnt_reg <= cnt_reg + 4'h1;
          end else if (byte_done) begin
            state_reg <= ST_WR_ACK;
            sda_oe_reg <= 1'b1;
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            state_reg <= ST_WRITE;
            cnt_reg <= CNT_ZERO;
            sda_oe_reg <= 1'b0;
          end
        end
        ST_READ: begin
          if (scl_rise) begin
            cnt_reg <= cnt_reg + 4'h1;
          end else if (byte_done) begin
            state_reg <= ST_RD_ACK;
            sda_oe_reg <= 1'b0;
          end else if (scl_fall) begin
            shift_reg <= {shift_reg[6:0], 1'b0};
            sda_oe_reg <= !shift_reg[6];
          end
        end
        ST_RD_ACK: begin
          if (scl_rise && sda_s) begin
            state_reg <= ST_IDLE;
          end else if (scl_fall) begin
            state_reg <= ST_READ;
            cnt_reg <= CNT_ZERO;
            shift_reg <= read_src;
            sda_oe_reg <= !read_src[7];
          end
        end
      endcase
    end
  end

  assign SDA_OUT = 1'b0;
  assign SDA_OE_OUT = sda_oe_reg;

  // ****************************************
  // Port latches
  // ****************************************
  // Reset loads the strapped defaults; the bus-clear input leaves them alone
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      pp_reg <= pp_def_s;
    end else if (pp_wr_pulse) begin
      pp_reg <= shift_reg;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      od_reg <= od_def_s;
    end else if (od_wr_pulse) begin
      od_reg <= shift_reg;
    end
  end

  assign PUSH_PULL_OUT = pp_reg;
  assign OPEN_DRAIN_IO_OUT = BYTE_ZERO;
  // A written one releases the pin and makes it usable as an input
  assign OPEN_DRAIN_IO_OE_OUT = ~od_reg;

  // ****************************************
  // Transition detection
  // ****************************************
  // Masks changes for a few cycles after an open-drain write or a reset while the pins settle
  logic [2:0] guard_reg;
  logic [7:0] od_prev_reg, flag_reg;
  logic alert_reg;

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      guard_reg <= WR_GUARD_CYC;
    end else if (od_wr_pulse) begin
      guard_reg <= WR_GUARD_CYC;
    end else if (guard_reg != GUARD_ZERO) begin
      guard_reg <= guard_reg - 3'h1;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      od_prev_reg <= od_pin_s; // Tracks the pins so release brings no false edge
    end else begin
      od_prev_reg <= od_pin_s;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      logic chg;
      // Ports driven low never flag; set wins over a same-cycle clear
      assign chg = (od_pin_s[gi] != od_prev_reg[gi]) && od_reg[gi] && !od_wr_pulse &&
                   (guard_reg == GUARD_ZERO);
      always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
          flag_reg[gi] <= 1'b0;
        end else if (chg) begin
          flag_reg[gi] <= 1'b1;
        end else if (access_pulse) begin
          flag_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      alert_reg <= 1'b0;
    end else begin
      alert_reg <= |flag_reg;
    end
  end

  assign CHANGE_ALERT_OUT = 1'b0;
  assign CHANGE_ALERT_OE_OUT = alert_reg;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_access;
    access_pulse;
  endsequence

  sequence s_od_write;
    od_wr_pulse ##1 1'b1;
  endsequence

  property p_bus_clear;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      !bus_clr_n_s |=> (state_reg == ST_IDLE) && !SDA_OE_OUT;
  endproperty
  a_bus_clear: assert property (p_bus_clear) else $error("bus clear did not idle engine");

  property p_addr_ack;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN || !bus_clr_n_s)
      (state_reg == ST_ADDR) && byte_done && !start_cond && !stop_cond &&
      (shift_reg[7:5] == PUSH_PULL_PREFIX || shift_reg[7:5] == OPEN_DRAIN_PREFIX) &&
      (shift_reg[4:1] == addr_low_s) |=> SDA_OE_OUT && (state_reg == ST_ADDR_ACK);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");

  property p_od_write;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      od_wr_pulse |=> (OPEN_DRAIN_IO_OE_OUT == ~$past(shift_reg)) && $stable(PUSH_PULL_OUT);
  endproperty
  a_od_write: assert property (p_od_write) else $error("open-drain write wrong or leaked");

  property p_pp_write;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      pp_wr_pulse |=> (PUSH_PULL_OUT == $past(shift_reg)) && $stable(OPEN_DRAIN_IO_OE_OUT);
  endproperty
  a_pp_write: assert property (p_pp_write) else $error("push-pull write wrong or leaked");

  property p_read_load;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN || !bus_clr_n_s)
      (state_reg == ST_ADDR_ACK) && scl_fall && shift_reg[0] && !start_cond && !stop_cond
      |=> (shift_reg == $past(read_src)) && (SDA_OE_OUT == !$past(read_src[7]));
  endproperty
  a_read_load: assert property (p_read_load) else $error("read data not from pins");

  property p_flag_set;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (g_flag[0].chg || g_flag[7].chg) |=> (flag_reg[0] || flag_reg[7]) ##1 CHANGE_ALERT_OE_OUT;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("input change not latched");

  property p_access_clear;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      s_access ##0 !(|{g_flag[0].chg, g_flag[1].chg, g_flag[2].chg, g_flag[3].chg,
                      g_flag[4].chg, g_flag[5].chg, g_flag[6].chg, g_flag[7].chg})
      |=> (flag_reg == BYTE_ZERO);
  endproperty
  a_access_clear: assert property (p_access_clear) else $error("flags survived access");

  property p_alert_release;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      $fell(|flag_reg) |=> !CHANGE_ALERT_OE_OUT;
  endproperty
  a_alert_release: assert property (p_alert_release) else $error("alert not released");

  property p_write_quiet;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      s_od_write |-> (guard_reg == WR_GUARD_CYC) ##1 (guard_reg != GUARD_ZERO)[*3];
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("write guard missing");

endmodule

// >>> common/i2cpx_pkg.sv
package i2cpx_pkg;
  // ****************************************
  // Bus and timing constants
  // ****************************************
  localparam int unsigned SYS_CLK_HZ = 10_000_000;
  localparam int unsigned BUS_MAX_HZ = 400_000;
  localparam int unsigned BUS_MIN_PERIOD_CYC = SYS_CLK_HZ / BUS_MAX_HZ;
  // Settle time after an open-drain write: two sync stages plus margin
  localparam logic [2:0] WR_GUARD_CYC = 3'h4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // ****************************************
  // Address layout
  // ****************************************
  localparam int unsigned ADDR_PREFIX_MSB = 7;
  localparam int unsigned ADDR_PREFIX_LSB = 5;
  localparam logic [2:0] PUSH_PULL_PREFIX = 3'h5;
  localparam logic [2:0] OPEN_DRAIN_PREFIX = 3'h6;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [2:0] GUARD_ZERO = 3'h0;
  // ****************************************
  // Serial engine states
  // ****************************************
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_WRITE = 7'h08,
    ST_WR_ACK = 7'h10,
    ST_READ = 7'h20,
    ST_RD_ACK = 7'h40
  } i2cpx_state_e;
endpackage

// >>> verification/i2cpx_master.sv
`timescale 1ns/100ps
// ****************
// Bus master model
// ****************
module i2cpx_master (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  // Extra low time: lets a scenario run the bus slowly
  int stretch = 0;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // 13 low plus 12 high cycles: 400kHz, never faster
  task automatic bit_io(input logic b, output logic r);
    cyc(6 + stretch);
    sda_out <= b;
    cyc(7);
    scl_out <= 1'b1;
    cyc(6);
    r = sda_in;
    cyc(6);
    scl_out <= 1'b0;
  endtask
  task automatic start_c();
    sda_out <= 1'b1;
    cyc(6);
    scl_out <= 1'b1;
    cyc(6);
    sda_out <= 1'b0;
    cyc(6);
    scl_out <= 1'b0;
  endtask
  task automatic stop_c();
    cyc(6);
    sda_out <= 1'b0;
    cyc(7);
    scl_out <= 1'b1;
    cyc(6);
    sda_out <= 1'b1;
    cyc(13);
  endtask
  // Nine bits out and in; a 1 releases the line
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
  endtask
endmodule

// >>> verification/i2cpx_bench.sv
`timescale 1ns/100ps
// **************
// Expander bench
// **************
module i2cpx_bench import i2cpx_pkg::*;;
  localparam logic [7:0] PP_DEF = 8'hA5;
  localparam logic [7:0] OD_DEF = 8'h0F;
  logic clk = 1'b0;
  logic rst_n;
  logic clr_n;
  logic [1:0] sel_hi;
  logic [1:0] sel_lo;
  logic [7:0] ext;
  logic [7:0] pp_def;
  logic [7:0] od_def;
  logic scl;
  logic sda_m;
  logic sda_oe;
  logic alert_oe;
  logic [7:0] pp_out;
  logic [7:0] od_oe;
  logic ack;
  logic [7:0] rx;
  logic [8:0] r;
  wire sda_o;
  wire [7:0] od_o;
  wire alert_o;
  // Open drain: an enabled driver shows its level, a released line its pull-up
  wire sda = sda_m & (~sda_oe | sda_o);
  // Pull-ups: a released pin follows the outside driver
  wire [7:0] pins = ext & (~od_oe | od_o);
  int error_cnt = 0;
  int comparisons = 0;
  i2cpx_top dut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .BUS_CLEAR_N_IN(clr_n),
    .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe),
    .ADDR_SELECT_LOW_IN(sel_lo), .ADDR_SELECT_HIGH_IN(sel_hi),
    .PUSH_PULL_DEFAULT_IN(pp_def), .OPEN_DRAIN_DEFAULT_IN(od_def),
    .PUSH_PULL_OUT(pp_out), .OPEN_DRAIN_IO_IN(pins), .OPEN_DRAIN_IO_OUT(od_o),
    .OPEN_DRAIN_IO_OE_OUT(od_oe), .CHANGE_ALERT_OUT(alert_o), .CHANGE_ALERT_OE_OUT(alert_oe));
  i2cpx_master mst (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_out(sda_m));
  initial begin
    forever #50 clk = ~clk;
  end
  // *******
  // Helpers
  // *******
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wait_alert(input logic v);
    int n = 0;
    while (alert_oe !== v && n < 20) begin
      @(posedge clk);
      n++;
    end
    check(8'(alert_oe), 8'(v));
    if (alert_oe !== v) tally_and_finish();
  endtask
  function automatic logic [7:0] ab(input logic [2:0] p, input logic rd);
    return {p, sel_hi, sel_lo, rd};
  endfunction
  // One-byte access; a read ends with a master not-acknowledge
  task automatic acc(input logic [7:0] a, input logic [7:0] d);
    mst.start_c();
    mst.xfer({a, 1'b1}, r);
    ack = ~r[0];
    if (ack) begin
      mst.xfer({d, 1'b1}, r);
      rx = r[8:1];
    end
    mst.stop_c();
  endtask
  // *********
  // Scenarios
  // *********
  task automatic t_reset();
    check(pp_out, PP_DEF);
    check(od_oe, ~OD_DEF);
    check(8'(alert_oe), 8'h00);
    check(8'(sda_o), 8'h00);
    check(od_o, 8'h00);
    check(8'(alert_o), 8'h00);
    $display("reset done");
  endtask
  task automatic t_sel();
    for (int i = 0; i < 16; i++) begin
      sel_hi <= i[3:2];
      sel_lo <= i[1:0];
      mst.stretch = i[0] ? 20 : 0;
      mst.cyc(4);
      acc(ab(PUSH_PULL_PREFIX, 1'b0), 8'(8'h01 << i[2:0]));
      check(8'(ack), 8'h01);
      check(pp_out, 8'(8'h01 << i[2:0]));
      check(od_oe, ~OD_DEF);
    end
    mst.stretch = 0;
    acc({3'h7, sel_hi, sel_lo, 1'b0}, 8'h00);
    check(8'(ack), 8'h00);
    acc({PUSH_PULL_PREFIX, ~sel_hi, sel_lo, 1'b0}, 8'h00);
    check(8'(ack), 8'h00);
    check(pp_out, 8'h80);
    $display("select done");
  endtask
  task automatic t_od();
    acc(ab(OPEN_DRAIN_PREFIX, 1'b0), 8'hFF);
    check(od_oe, 8'h00);
    acc(ab(OPEN_DRAIN_PREFIX, 1'b0), 8'h0F);
    check(od_oe, 8'hF0);
    check(pp_out, 8'h80);
    mst.cyc(20);
    check(8'(alert_oe), 8'h00);
    acc(ab(OPEN_DRAIN_PREFIX, 1'b1), 8'hFF);
    check(rx, 8'h0F);
    acc(ab(OPEN_DRAIN_PREFIX, 1'b0), 8'hFF);
    mst.cyc(20);
    check(8'(alert_oe), 8'h00);
    $display("open-drain done");
  endtask
  task automatic t_alert();
    ext <= 8'hFB;
    mst.cyc(3);
    ext <= 8'hFF;
    wait_alert(1'b1);
    mst.cyc(50);
    check(8'(alert_oe), 8'h01);
    ext <= 8'h7E;
    mst.cyc(5);
    acc(ab(OPEN_DRAIN_PREFIX, 1'b1), 8'hFF);
    check(rx, 8'h7E);
    check(8'(alert_oe), 8'h00);
    ext <= 8'hFF;
    wait_alert(1'b1);
    acc(ab(PUSH_PULL_PREFIX, 1'b0), 8'hC3);
    check(8'(alert_oe), 8'h00);
    check(pp_out, 8'hC3);
    $display("alert done");
  endtask
  // Clear while the device drives a read bit low
  task automatic t_abort();
    ext <= 8'h7F;
    mst.start_c();
    mst.xfer({ab(OPEN_DRAIN_PREFIX, 1'b1), 1'b1}, r);
    mst.cyc(8);
    check(8'(sda_oe), 8'h01);
    clr_n <= 1'b0;
    mst.cyc(5);
    check(8'(sda_oe), 8'h00);
    clr_n <= 1'b1;
    mst.cyc(5);
    mst.stop_c();
    acc(ab(PUSH_PULL_PREFIX, 1'b0), 8'h3C);
    check(8'(ack), 8'h01);
    check(pp_out, 8'h3C);
    $display("abort done");
  endtask
  // Straps act only while reset is held; a second reset loads new ones
  task automatic t_strap();
    pp_def <= 8'h5A;
    od_def <= 8'hF0;
    mst.cyc(5);
    check(pp_out, 8'h3C);
    check(od_oe, 8'h00);
    rst_n <= 1'b0;
    mst.cyc(4);
    rst_n <= 1'b1;
    mst.cyc(4);
    check(pp_out, 8'h5A);
    check(od_oe, 8'h0F);
    check(8'(alert_oe), 8'h00);
    acc(ab(PUSH_PULL_PREFIX, 1'b1), 8'hFF);
    check(rx, 8'h5A);
    acc(ab(OPEN_DRAIN_PREFIX, 1'b1), 8'hFF);
    check(rx, 8'h70);
    check(8'(alert_oe), 8'h00);
    $display("strap done");
  endtask
  initial begin
    rst_n <= 1'b0;
    clr_n <= 1'b1;
    sel_hi <= 2'h2;
    sel_lo <= 2'h1;
    ext <= 8'hFF;
    pp_def <= PP_DEF;
    od_def <= OD_DEF;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_sel();
    t_od();
    t_alert();
    t_abort();
    t_strap();
    tally_and_finish();
  end
endmodule
